// ### src/dis_top.sv
// Digital input scanner: sync, scan tick, channels, routing and Avalon-MM registers
// Contract
// - Sample every input once per scan cycle
// - Internal consumers act one scan later
// - Output contacts update one further scan
// - Card channels numbered after preceding inputs
// - Card thresholds programmable in one volt steps
// - Card scanned alike, delays and polarity set
// - Card channels behave like main channels
// - Polarity selects energized reading, NO default
// - Separate rise and fall delays in ms
// - AC mode adds thirty ms release hold
// - 32-bit rise counter with software clear
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module dis_top #(
  parameter int NM          = dis_pkg::NUM_MAIN,
  parameter int NC          = dis_pkg::NUM_CARD,
  parameter int NO          = dis_pkg::NUM_OUT,
  parameter int SCAN_CYCLES = dis_pkg::SCAN_CYC
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rstn,
  input  wire logic [NM-1:0]                 din_pin,
  input  wire logic [NC*dis_pkg::VOLT_W-1:0] card_volt,
  input  wire logic [11:0]                   avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic [31:0]                        avs_readdata,
  output logic                               avs_waitrequest,
  output logic [NM+NC-1:0]                   cons_state,
  output logic [NO-1:0]                      output_contact
);

  // ****************************************
  // Sizes
  // ****************************************
  // Main inputs first, then the card
  localparam int NCH = NM + NC;  // All numbered_input_channel
  // Four bit index: at most 16 channels

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Pin synchroniser
    logic [NM-1:0]                          sync1;    // First sync stage
    logic [NM-1:0]                          sync2;    // Second sync stage

    // Program cycle timing
    logic [31:0]                            scan_cnt; // Program cycle divider
    logic                                   tick;     // One cycle per scan

    // Bus answer
    logic                                   wait_r;   // Waitrequest
    logic [31:0]                            rdata;    // Read data

    // Channel settings
    logic [NCH-1:0]                         pol;      // Normally closed
    logic [NCH-1:0]                         ac;       // AC mode
    logic [NCH-1:0]                         clr;      // Counter clear pulse
    logic [NCH-1:0][dis_pkg::THR_W-1:0]     act_thr;  // Activation volts
    logic [NCH-1:0][dis_pkg::THR_W-1:0]     rel_thr;  // Release volts
    logic [NCH-1:0][dis_pkg::DLY_W-1:0]     act_dly;  // Rise delay ms
    logic [NCH-1:0][dis_pkg::DLY_W-1:0]     rel_dly;  // Fall delay ms

    // Contact routing
    logic [NO-1:0][3:0]                     sel;      // Contact source channel
    logic [NO-1:0]                          en;       // Contact routing enable

    // Scan stages
    logic [NCH-1:0]                         cons;     // Consumer copy
    logic [NO-1:0]                          contact;  // Contact drive
  } dis_top_t;

  // Block state and next value
  dis_top_t                       r_ff;       // Registered state
  dis_top_t                       nxt_r;      // Next state

  // Channel results
  logic [NCH-1:0]                 raw;        // Energized levels
  logic [NCH-1:0]                 chan_st;    // Qualified states
  logic [NCH-1:0][31:0]           chan_cnt;   // Rise counters

  // Bus decode
  logic [31:0]                    rd;         // Addressed word
  logic [31:0]                    wv;         // Merged write word
  logic [31:0]                    be_mask;    // Byte enables as bits
  logic [3:0]                     ch;         // Addressed channel
  logic [1:0]                     sub;        // Word in channel block
  logic                           ch_hit;     // Channel block hit

  // ****************************************
  // Channels
  // ****************************************
  // Main pins skip the comparator;
  // their level is used as is
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      if (gi < NM) begin : g_main
        // Second sync stage only
        assign raw[gi] = r_ff.sync2[gi];
      end else begin : g_card
        // Card channel threshold stage
        // Card volts are on this clock
        dis_hyst u_hyst (
          .clk_sys (clk_sys),
          .rstn    (rstn),
          .volt    (card_volt[(gi-NM)*dis_pkg::VOLT_W +: dis_pkg::VOLT_W]),
          .act_thr (r_ff.act_thr[gi]),
          .rel_thr (r_ff.rel_thr[gi]),
          .ac_mode (r_ff.ac[gi]),
          .level   (raw[gi])
        );
      end

      // Same conditioning for every channel
      // so card and main channels match
      dis_chan u_chan (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .scan_tick (r_ff.tick),
        .raw_level (raw[gi]),
        .pol_nc    (r_ff.pol[gi]),
        .ac_mode   (r_ff.ac[gi]),
        .act_dly   (r_ff.act_dly[gi]),
        .rel_dly   (r_ff.rel_dly[gi]),
        .cnt_clr   (r_ff.clr[gi]),
        .state     (chan_st[gi]),
        .count     (chan_cnt[gi])
      );
    end
  endgenerate

  // ****************************************
  // Address decode and read word
  // ****************************************
  // Blocks of 16 bytes per channel
  assign ch      = avs_address[7:4];
  // Word within the block
  assign sub     = avs_address[3:2];
  assign ch_hit  = (avs_address[11:8] == dis_pkg::REG_CH[11:8]) && (32'(ch) < NCH);
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // Lanes not enabled keep old bits
  assign wv      = (rd & ~be_mask) | (avs_writedata & be_mask);

  // Select the word at the bus address, zero if unmapped
  always_comb begin
    // Default for unmapped places
    rd = '0;
    // Channel numbering
    if (avs_address == dis_pkg::REG_INFO) begin
      rd[7:0]                        = 8'(NM);
      rd[dis_pkg::INFO_CRD +: 8]     = 8'(NM + 1);
    end else if (avs_address == dis_pkg::REG_STATE) begin
      // One bit per channel
      rd[NCH-1:0] = chan_st;
    end else if (avs_address == dis_pkg::REG_ROUTE) begin
      // Source and enable per contact
      for (int o = 0; o < NO; o++) begin
        rd[o*4 +: 4]             = r_ff.sel[o];
        rd[dis_pkg::ROUTE_EN + o] = r_ff.en[o];
      end
    end else if (ch_hit) begin
      // Four words per channel
      if (sub == dis_pkg::SUB_CFG) begin
        rd[dis_pkg::CFG_POL]           = r_ff.pol[ch];
        rd[dis_pkg::CFG_AC]            = r_ff.ac[ch];
        rd[dis_pkg::CFG_ACT +: 8]      = r_ff.act_thr[ch];
        rd[dis_pkg::CFG_REL +: 8]      = r_ff.rel_thr[ch];
      end else if (sub == dis_pkg::SUB_ACT) begin
        rd[dis_pkg::DLY_W-1:0] = r_ff.act_dly[ch];
      end else if (sub == dis_pkg::SUB_REL) begin
        rd[dis_pkg::DLY_W-1:0] = r_ff.rel_dly[ch];
      end else begin
        // Counter is read only
        rd = chan_cnt[ch];
      end
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_r       = r_ff;
    // Two flops before any logic reads a pin
    nxt_r.sync1 = din_pin;
    nxt_r.sync2 = r_ff.sync1;
    // Clear lasts one cycle
    nxt_r.clr   = '0;

    // Program cycle divider
    // Tick ends each 5 ms cycle
    if (r_ff.scan_cnt == 32'(SCAN_CYCLES - 1)) begin
      nxt_r.scan_cnt = '0;
      // One pulse times all channels
      nxt_r.tick     = 1'b1;
    end else begin
      nxt_r.scan_cnt = r_ff.scan_cnt + 32'h0000_0001;
      nxt_r.tick     = 1'b0;
    end

    // Consumers and contacts each lag one scan
    // Old states move on one stage
    if (r_ff.tick) begin
      // States of the last tick
      nxt_r.cons = chan_st;
      for (int o = 0; o < NO; o++) begin
        // Out of range source drives zero
        nxt_r.contact[o] = r_ff.en[o] && (32'(r_ff.sel[o]) < NCH) && r_ff.cons[r_ff.sel[o]];
      end
    end

    // Bus: accept, answer next cycle, then rearm
    // Waitrequest is low one cycle;
    // the write lands in that cycle
    if ((avs_read || avs_write) && r_ff.wait_r) begin
      // Request taken, answer next cycle
      nxt_r.wait_r = 1'b0;
      // Word held until next request
      nxt_r.rdata  = avs_read ? rd : '0;
    end else begin
      nxt_r.wait_r = 1'b1;
      if (!r_ff.wait_r && avs_write) begin
        // Settings change at the answer edge
        if (avs_address == dis_pkg::REG_CLEAR) begin
          nxt_r.clr = avs_writedata[NCH-1:0] & be_mask[NCH-1:0];
        end else if (avs_address == dis_pkg::REG_ROUTE) begin
          for (int o = 0; o < NO; o++) begin
            // Source and enable per contact
            nxt_r.sel[o] = wv[o*4 +: 4];
            nxt_r.en[o]  = wv[dis_pkg::ROUTE_EN + o];
          end
        end else if (ch_hit) begin
          if (sub == dis_pkg::SUB_CFG) begin
            // Polarity, AC and thresholds
            nxt_r.pol[ch]     = wv[dis_pkg::CFG_POL];
            nxt_r.ac[ch]      = wv[dis_pkg::CFG_AC];
            nxt_r.act_thr[ch] = wv[dis_pkg::CFG_ACT +: 8];
            nxt_r.rel_thr[ch] = wv[dis_pkg::CFG_REL +: 8];
          end else if (sub == dis_pkg::SUB_ACT) begin
            // Low bits only
            nxt_r.act_dly[ch] = wv[dis_pkg::DLY_W-1:0];
          end else if (sub == dis_pkg::SUB_REL) begin
            // Same width as the rise delay
            nxt_r.rel_dly[ch] = wv[dis_pkg::DLY_W-1:0];
          end
        end
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Synchronous, active low reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // Everything clears first
      r_ff         <= '0;
      // Bus stalls while idle
      r_ff.wait_r  <= 1'b1;
      // Thresholds start at nonzero volts
      r_ff.act_thr <= {NCH{dis_pkg::ACT_THR_RST}};
      r_ff.rel_thr <= {NCH{dis_pkg::REL_THR_RST}};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Straight from flip-flops
  assign avs_readdata    = r_ff.rdata;
  assign avs_waitrequest = r_ff.wait_r;
  assign cons_state      = r_ff.cons;
  assign output_contact  = r_ff.contact;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Scan path lags
  consumer_lag_a: assert property (r_ff.tick |=> cons_state == $past(chan_st))
    else $error("consumer copy not taken on tick");
  contact_lag_a: assert property (r_ff.tick && r_ff.en[0] && r_ff.sel[0] == 4'h0 |=> output_contact[0] == $past(r_ff.cons[0]))
    else $error("contact not driven from consumer copy");
  tick_period_a: assert property (r_ff.tick |=> !r_ff.tick)
    else $error("scan tick longer than one cycle");

  // Bus handshake
  card_number_a: assert property (avs_read && avs_address == dis_pkg::REG_INFO && avs_waitrequest |=> avs_readdata[15:8] == 8'(NM + 1))
    else $error("card numbering wrong");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  // Pin synchroniser
  sync_stage_a: assert property ($past(rstn, 2) |-> r_ff.sync2 == $past(din_pin, 2))
    else $error("pin not two flops late");
endmodule // dis_top

// ### src/dis_pkg.sv
// Constants shared by the digital input scanner files
package dis_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 20_000_000;               // System clock rate
  localparam int SCAN_MS    = 5;                        // Program cycle length in ms
  localparam int SCAN_CYC   = CLK_HZ / 1000 * SCAN_MS;  // Clock cycles per program cycle
  localparam int AC_HOLD_MS = 30;                       // Extra release delay in AC mode
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_MAIN = 3;   // Inputs on the main module
  localparam int NUM_CARD = 8;   // Inputs on the eight_input_card
  localparam int NUM_OUT  = 5;   // Output contacts
  localparam int DLY_W    = 21;  // Delay in ms, up to 1800000
  localparam int THR_W    = 8;   // Threshold in volts
  localparam int VOLT_W   = 9;   // Measured volts, up to 275
  localparam int CNT_W    = 32;  // Rising transition counter
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ACT_THR_RST = 8'h58;  // 88 V
  localparam logic [7:0] REL_THR_RST = 8'h3c;  // 60 V
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] REG_INFO   = 12'h000;  // Channel numbering
  localparam logic [11:0] REG_STATE  = 12'h004;  // Scanned states
  localparam logic [11:0] REG_CLEAR  = 12'h008;  // Counter clear mask
  localparam logic [11:0] REG_ROUTE  = 12'h00c;  // Contact routing
  localparam logic [11:0] REG_CH     = 12'h100;  // First channel block
  localparam logic [1:0]  SUB_CFG    = 2'h0;     // Channel config word
  localparam logic [1:0]  SUB_ACT    = 2'h1;     // Activation delay word
  localparam logic [1:0]  SUB_REL    = 2'h2;     // Release delay word
  localparam logic [1:0]  SUB_CNT    = 2'h3;     // Counter word
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_POL  = 0;   // Normally closed when set
  localparam int CFG_AC   = 1;   // AC mode
  localparam int CFG_ACT  = 8;   // Activation threshold LSB
  localparam int CFG_REL  = 16;  // Release threshold LSB
  localparam int INFO_CRD = 8;   // First card channel number LSB
  localparam int ROUTE_EN = 20;  // Contact enables LSB
endpackage

// ### src/dis_hyst.sv
// Threshold comparator with hysteresis for one option card channel
`timescale 1ns/1ns
module dis_hyst (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic [dis_pkg::VOLT_W-1:0] volt,
  input  wire logic [dis_pkg::THR_W-1:0]  act_thr,
  input  wire logic [dis_pkg::THR_W-1:0]  rel_thr,
  input  wire logic                       ac_mode,
  output logic                            level
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic lvl;  // Energized level
  } dis_hyst_t;

  dis_hyst_t                r_ff;     // Registered state
  dis_hyst_t                nxt_r;    // Next state
  logic [dis_pkg::THR_W-1:0] rel_eff;  // Release threshold in use

  // AC mode forces release to a tenth of activation
  assign rel_eff = ac_mode ? act_thr / 8'h0a : rel_thr;

  // Rise above activation, fall below release, else hold
  always_comb begin
    nxt_r = r_ff;
    if (volt > {1'b0, act_thr}) begin
      nxt_r.lvl = 1'b1;
    end else if (volt < {1'b0, rel_eff}) begin
      nxt_r.lvl = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign level = r_ff.lvl;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  hyst_rise_a: assert property (volt > {1'b0, act_thr} |=> level)
    else $error("level not raised above activation");
  hyst_hold_a: assert property ((volt <= {1'b0, act_thr}) && (volt >= {1'b0, rel_eff}) |=> $stable(level))
    else $error("level moved inside hysteresis band");
endmodule // dis_hyst

// ### src/dis_chan.sv
// Per channel polarity, delays and transition counter
`timescale 1ns/1ns
module dis_chan (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      scan_tick,
  input  wire logic                      raw_level,
  input  wire logic                      pol_nc,
  input  wire logic                      ac_mode,
  input  wire logic [dis_pkg::DLY_W-1:0] act_dly,
  input  wire logic [dis_pkg::DLY_W-1:0] rel_dly,
  input  wire logic                      cnt_clr,
  output logic                           state,
  output logic [dis_pkg::CNT_W-1:0]      count
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                      st;    // Qualified status
    logic [dis_pkg::DLY_W:0]   elap;  // ms spent in disagreement
    logic [dis_pkg::CNT_W-1:0] cnt;   // Rising transitions
  } dis_chan_t;

  dis_chan_t               r_ff;   // Registered state
  dis_chan_t               nxt_r;  // Next state
  logic                    lvl;    // Status after polarity
  logic                    rise;   // Qualified 0 to 1 this cycle
  logic [dis_pkg::DLY_W:0] need;   // Delay to qualify
  logic [dis_pkg::DLY_W:0] step;   // Elapsed after this scan

  // Polarity: NC reads an energized input as zero
  assign lvl = raw_level ^ pol_nc;

  // Delay for the pending change, AC adds hold on release
  assign need = r_ff.st ? ({1'b0, rel_dly} + (ac_mode ? (dis_pkg::DLY_W+1)'(dis_pkg::AC_HOLD_MS) : '0))
                        : {1'b0, act_dly};
  assign step = r_ff.elap + (dis_pkg::DLY_W+1)'(dis_pkg::SCAN_MS);

  // Sample only on the program cycle tick
  always_comb begin
    nxt_r = r_ff;
    rise  = 1'b0;
    if (scan_tick) begin
      if (lvl == r_ff.st) begin
        nxt_r.elap = '0;
      end else if (step >= need) begin
        nxt_r.st   = lvl;
        nxt_r.elap = '0;
        rise       = lvl;
      end else begin
        nxt_r.elap = step;
      end
    end
    // Clear and a transition in the same cycle leave a count of one
    nxt_r.cnt = (cnt_clr ? '0 : r_ff.cnt) + {{(dis_pkg::CNT_W-1){1'b0}}, rise};
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign state = r_ff.st;
  assign count = r_ff.cnt;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  scan_only_a: assert property (!scan_tick |=> $stable(state))
    else $error("status moved off the scan tick");
  zero_delay_a: assert property (scan_tick && act_dly == '0 && !state && lvl |=> state)
    else $error("zero activation delay not immediate");
  ac_hold_a: assert property (scan_tick && ac_mode && state && !lvl && r_ff.elap == '0 |=> state)
    else $error("AC release taken without hold");
  count_clr_a: assert property (cnt_clr && !rise |=> count == '0)
    else $error("counter not cleared");
  count_inc_a: assert property (!cnt_clr && rise |=> count == $past(count) + 1)
    else $error("rise not counted");
endmodule // dis_chan

// ### tb/dis_field.sv
// Field contact model that energizes the main pins and the card channel voltages
`timescale 1ns/1ns
module dis_field (
  input  wire logic                                        clk_sys,
  output logic [dis_pkg::NUM_MAIN-1:0]                     din_pin,
  output logic [dis_pkg::NUM_CARD*dis_pkg::VOLT_W-1:0]     card_volt
);
  // ****************************************
  // Field levels
  // ****************************************
  // Contacts open and no voltage at power up
  initial begin
    din_pin   = '0;
    card_volt = '0;
  end
  // Energize or release one main contact just after an edge
  task automatic set_pin(input int i, input logic v);
    @(posedge clk_sys);
    din_pin[i] <= v;
  endtask
  // Apply a steady voltage to one card channel, held until changed
  task automatic set_volt(input int k, input logic [8:0] v);
    @(posedge clk_sys);
    card_volt[k*9+:9] <= v;
  endtask
endmodule // dis_field

// ### tb/dis_top_test.sv
// Self-checking bench for the digital input scanner
`timescale 1ns/1ns
module dis_top_test;
  // ****************************************
  // Signals
  // ****************************************
  localparam int SC = 20;                 // Short scan period, still 5 ms per tick
  logic        clk_sys;                   // System clock
  logic        rstn;                      // Active low reset
  logic [2:0]  din_pin;                   // Main pins from the field
  logic [71:0] card_volt;                 // Card voltages from the field
  logic [11:0] avs_address;               // Bus address
  logic        avs_read;                  // Bus read request
  logic        avs_write;                 // Bus write request
  logic [31:0] avs_writedata;             // Bus write data
  logic [31:0] avs_readdata;              // Bus read data
  logic        avs_waitrequest;           // Bus stall
  logic [10:0] cons_state;                // Consumer copy of states
  logic [4:0]  output_contact;            // Contact drive
  int          bad_count;                 // Mismatches
  int          n_compared;                // Comparisons made
  // ****************************************
  // Instances
  // ****************************************
  dis_top #(.SCAN_CYCLES(SC)) DUT (.clk_sys(clk_sys), .rstn(rstn), .din_pin(din_pin), .card_volt(card_volt),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cons_state(cons_state), .output_contact(output_contact));
  dis_field FLD (.clk_sys(clk_sys), .din_pin(din_pin), .card_volt(card_volt));
  // Clock at 20 MHz
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Helpers
  // ****************************************
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon-MM transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    chk("bus answer", 32'h0000_0000, {31'h0, avs_waitrequest});
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  // Register read compared under a mask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0000_0000, v);
    chk(what, e, v & m);
  endtask
  // Channel block address
  function automatic logic [11:0] ch_a(input int ch, input logic [1:0] sub);
    return dis_pkg::REG_CH + 12'(ch * 16) + {8'h00, sub, 2'h0};
  endfunction
  // Idle for a number of cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values, numbering and unmapped place
  task automatic t_reset;
    rd_chk("info", dis_pkg::REG_INFO, 32'h0000_ffff, 32'h0000_0403);
    rd_chk("card cfg", ch_a(3, dis_pkg::SUB_CFG), 32'h00ff_ff03, 32'h003c_5800);
    rd_chk("rise delay", ch_a(3, dis_pkg::SUB_ACT), 32'hffff_ffff, 32'h0000_0000);
    wr(12'h1b0, 32'hffff_ffff);
    rd_chk("unmapped", 12'h1b0, 32'hffff_ffff, 32'h0000_0000);
  endtask
  // Pin to consumer to contact, then counter clear
  task automatic t_path;
    int n;
    int m;
    n = 0;
    m = 0;
    wr(dis_pkg::REG_ROUTE, 32'h0010_0000);
    rd_chk("route", dis_pkg::REG_ROUTE, 32'hffff_ffff, 32'h0010_0000);
    FLD.set_pin(0, 1'b1);
    while (cons_state[0] !== 1'b1 && n < 4 * SC) begin
      @(posedge clk_sys);
      n++;
    end
    chk("consumer lag", 32'h1, {31'h0, n >= SC && n <= 2 * SC + 3});
    while (output_contact[0] !== 1'b1 && m < 2 * SC) begin
      @(posedge clk_sys);
      m++;
    end
    chk("contact lag", 32'(SC), 32'(m));
    rd_chk("state", dis_pkg::REG_STATE, 32'h0000_0001, 32'h0000_0001);
    rd_chk("count", ch_a(0, dis_pkg::SUB_CNT), 32'hffff_ffff, 32'h0000_0001);
    wr(dis_pkg::REG_CLEAR, 32'h0000_0001);
    rd_chk("cleared", ch_a(0, dis_pkg::SUB_CNT), 32'hffff_ffff, 32'h0000_0000);
    FLD.set_pin(0, 1'b0);
    cyc(3 * SC + 6);
    chk("contact off", 32'h0, {27'h0, output_contact});
  endtask
  // Normally closed polarity
  task automatic t_pol;
    wr(ch_a(1, dis_pkg::SUB_CFG), 32'h003c_5801);
    cyc(SC + 4);
    rd_chk("nc idle", dis_pkg::REG_STATE, 32'h0000_0002, 32'h0000_0002);
    FLD.set_pin(1, 1'b1);
    cyc(SC + 4);
    rd_chk("nc energized", dis_pkg::REG_STATE, 32'h0000_0002, 32'h0000_0000);
    FLD.set_pin(1, 1'b0);
  endtask
  // Rise delay 20 ms and fall delay 10 ms
  task automatic t_dly;
    wr(ch_a(2, dis_pkg::SUB_ACT), 32'h0000_0014);
    wr(ch_a(2, dis_pkg::SUB_REL), 32'h0000_000a);
    FLD.set_pin(2, 1'b1);
    cyc(3 * SC - 4);
    rd_chk("rise held", dis_pkg::REG_STATE, 32'h0000_0004, 32'h0000_0000);
    cyc(SC + 8);
    rd_chk("rise done", dis_pkg::REG_STATE, 32'h0000_0004, 32'h0000_0004);
    FLD.set_pin(2, 1'b0);
    cyc(SC - 4);
    rd_chk("fall held", dis_pkg::REG_STATE, 32'h0000_0004, 32'h0000_0004);
    cyc(SC + 8);
    rd_chk("fall done", dis_pkg::REG_STATE, 32'h0000_0004, 32'h0000_0000);
  endtask
  // Card channel thresholds, hysteresis and AC hold
  task automatic t_card;
    wr(ch_a(3, dis_pkg::SUB_CFG), 32'h0032_6400);
    FLD.set_volt(0, 9'h064);
    cyc(2 * SC);
    rd_chk("at act", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0000);
    FLD.set_volt(0, 9'h065);
    cyc(SC + 4);
    rd_chk("above act", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0008);
    FLD.set_volt(0, 9'h032);
    cyc(2 * SC);
    rd_chk("at rel", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0008);
    FLD.set_volt(0, 9'h031);
    cyc(SC + 4);
    rd_chk("below rel", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0000);
    wr(ch_a(3, dis_pkg::SUB_CFG), 32'h0032_6402);
    FLD.set_volt(0, 9'h078);
    cyc(SC + 4);
    FLD.set_volt(0, 9'h00b);
    cyc(2 * SC);
    rd_chk("ac rel hold", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0008);
    FLD.set_volt(0, 9'h009);
    cyc(5 * SC - 4);
    rd_chk("ac hold", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0008);
    cyc(SC + 8);
    rd_chk("ac drop", dis_pkg::REG_STATE, 32'h0000_0008, 32'h0000_0000);
    rd_chk("card count", ch_a(3, dis_pkg::SUB_CNT), 32'hffff_ffff, 32'h0000_0002);
  endtask
  // ****************************************
  // Run control
  // ****************************************
  // Verdict and end of run
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (8000) @(posedge clk_sys);
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    rstn          = 1'b0;
    avs_address   = 12'h000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    bad_count     = 0;
    n_compared    = 0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_path();
    t_pol();
    t_dly();
    t_card();
    report_and_stop();
  end
endmodule // dis_top_test
